// [verilog/uief_top.sv]
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module uief_top
	import uief_pkg::*;
(
	input  wire logic                  aclk,         // System clock, 25 MHz.
	input  wire logic                  aresetn,      // Synchronous reset, active low.
	input  wire logic [AXI_ADDR_W-1:0] awaddr,       // Write address.
	input  wire logic                  awvalid,      // Write address valid.
	output logic                       awready,      // Write address ready.
	input  wire logic [AXI_DATA_W-1:0] wdata,        // Write data.
	input  wire logic [3:0]            wstrb,        // Write byte enables.
	input  wire logic                  wvalid,       // Write data valid.
	output logic                       wready,       // Write data ready.
	output logic [1:0]                 bresp,        // Write response.
	output logic                       bvalid,       // Write response valid.
	input  wire logic                  bready,       // Write response ready.
	input  wire logic [AXI_ADDR_W-1:0] araddr,       // Read address.
	input  wire logic                  arvalid,      // Read address valid.
	output logic                       arready,      // Read address ready.
	output logic [AXI_DATA_W-1:0]      rdata,        // Read data.
	output logic [1:0]                 rresp,        // Read response.
	output logic                       rvalid,       // Read data valid.
	input  wire logic                  rready,       // Read data ready.
	input  wire logic                  host_mode,    // High in host mode.
	input  wire logic                  evt_suspend,  // Suspend seen, pulse.
	input  wire logic                  evt_resume,   // Resume seen, pulse.
	input  wire logic                  evt_babble,   // Babble seen, pulse.
	input  wire logic                  evt_bus_rst,  // Bus reset seen, pulse.
	input  wire logic                  evt_sof,      // Frame start, pulse.
	input  wire logic                  attach_event, // Attach seen, pulse.
	input  wire logic                  detach_event, // Detach seen, pulse.
	input  wire logic                  sof_sent,     // Frame start sent, pulse.
	input  wire logic                  frame_valid,  // Frame number received.
	input  wire logic [FRAME_W-1:0]    frame_num,    // Received frame number.
	output logic                       irq           // Interrupt request.
);

	// ---------------------------------------------------------------
	// Declarations.
	// ---------------------------------------------------------------
	uief_reg_if bus ();

	logic [IRQ_W-1:0]   bus_irq_enable_reg;
	logic [IRQ_W-1:0]   enable_view;
	logic [IRQ_W-1:0]   bus_irq_status_reg;
	logic [IRQ_W-1:0]   status_set;
	logic [IRQ_W-1:0]   status_clr;
	logic [IRQ_W-1:0]   mode_mask;
	logic [IRQ_W-1:0]   raw_events;
	logic [IRQ_W-1:0]   pending;
	logic [FRAME_W-1:0] frame_count;
	logic [FREG_W-1:0]  frame_number_reg;
	logic               first_sof_done;
	logic               babble_ok;
	logic               enable_write;
	logic               status_read;

	// ---------------------------------------------------------------
	// Bus slave.
	// ---------------------------------------------------------------

	// The slave answers every access; unmapped ones get an error response.
	uief_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.bus     (bus.slave)
	);

	// ---------------------------------------------------------------
	// Mode layout.
	// ---------------------------------------------------------------

	// The writable bits depend on the mode the controller is in now.
	always_comb
	begin
		if (host_mode)
			mode_mask = MASK_HOST;
		else
			mode_mask = MASK_DEVICE;
	end

	// ---------------------------------------------------------------
	// Enable register.
	// ---------------------------------------------------------------

	// Only byte lane 0 carries the enable bits.
	assign enable_write = bus.wr_en && (bus.wr_idx == IDX_ENABLE) && bus.wr_strb[0];

	// Bits outside the current layout keep their value on a write.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bus_irq_enable_reg <= IE_RESET;
		else if (enable_write)
			bus_irq_enable_reg <= (bus_irq_enable_reg & ~mode_mask)
				| (bus.wr_data[IRQ_W-1:0] & mode_mask);
	end

	// Reserved positions of the current mode read back as zero.
	assign enable_view = bus_irq_enable_reg & mode_mask;

	// ---------------------------------------------------------------
	// Status flags.
	// ---------------------------------------------------------------

	// Babble stays quiet until the host has sent its first frame start.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			first_sof_done <= 1'b0;
		else if (host_mode && sof_sent)
			first_sof_done <= 1'b1;
	end

	assign babble_ok = host_mode && first_sof_done;

	// Bit 2 is babble in host mode and bus reset in device mode.
	always_comb
	begin
		raw_events = STATUS_RESET;
		raw_events[BIT_SUSPEND] = evt_suspend;
		raw_events[BIT_RESUME]  = evt_resume;
		raw_events[BIT_SOF]     = evt_sof;
		raw_events[BIT_ATTACH]  = attach_event;
		raw_events[BIT_DETACH]  = detach_event;
		if (host_mode)
			raw_events[BIT_BABBLE] = evt_babble && babble_ok;
		else
			raw_events[BIT_BUSRST] = evt_bus_rst;
	end

	assign status_set = raw_events & mode_mask;

	// Reading the status register clears it; a new event in that cycle stays.
	assign status_read = bus.rd_en && (bus.rd_idx == IDX_STATUS);
	assign status_clr  = status_read ? ~STATUS_RESET : STATUS_RESET;

	uief_sticky #(
		.W (IRQ_W)
	) u_status (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set     (status_set),
		.clr     (status_clr),
		.q       (bus_irq_status_reg)
	);

	// ---------------------------------------------------------------
	// Interrupt request.
	// ---------------------------------------------------------------

	// Each flag reaches the request only through its own enable bit.
	assign pending = bus_irq_status_reg & enable_view;
	// Bit 2 follows the layout of the mode, babble or bus reset.

	// Registered so the interrupt line is glitch free.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |pending;
	end

	// ---------------------------------------------------------------
	// Frame number.
	// ---------------------------------------------------------------

	// Holds the most recent frame number until the next one arrives.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			frame_count <= FRAME_RESET;
		else if (frame_valid)
			frame_count <= frame_num;
	end

	// Upper bits are tied off so they can never read other than zero.
	assign frame_number_reg = {{(FREG_W-FRAME_W){1'b0}}, frame_count};

	// ---------------------------------------------------------------
	// Read and write decode.
	// ---------------------------------------------------------------

	// Writes to the read-only registers are accepted and dropped.
	always_comb
	begin
		case (bus.wr_idx)
			IDX_STATUS: bus.wr_hit = 1'b1;
			IDX_ENABLE: bus.wr_hit = 1'b1;
			IDX_FRAME:  bus.wr_hit = 1'b1;
			default:    bus.wr_hit = 1'b0;
		endcase
	end

	// Narrow registers sit in the low bits; the rest read zero.
	always_comb
	begin
		bus.rd_data = '0;
		bus.rd_hit  = 1'b1;
		case (bus.rd_idx)
			IDX_STATUS: bus.rd_data[IRQ_W-1:0]  = bus_irq_status_reg;
			IDX_ENABLE: bus.rd_data[IRQ_W-1:0]  = enable_view;
			IDX_FRAME:  bus.rd_data[FREG_W-1:0] = frame_number_reg;
			default:    bus.rd_hit = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Assertions.
	// ---------------------------------------------------------------

	default clocking cb @(posedge aclk);
	endclocking

	default disable iff (!aresetn);

	// The enable register starts from its documented value.
	enable_reset_a: assert property (
		$past(!aresetn) |-> (bus_irq_enable_reg == IE_RESET))
		else $error("Enable register wrong after reset.");

	// A write lands in the writable bits of the current mode only.
	enable_write_a: assert property (
		enable_write |=> (enable_view == ($past(bus.wr_data[IRQ_W-1:0])
			& $past(mode_mask))) || ($past(host_mode) != host_mode))
		else $error("Enable write not stored.");

	// Reserved bits never read as one.
	reserved_zero_a: assert property (
		(enable_view[IRQ_W-1:BIT_DETACH+1] == '0)
		&& (host_mode ? !enable_view[BIT_SUSPEND] : !enable_view[BIT_ATTACH]))
		else $error("Reserved enable bit reads one.");

	// An enabled detach flag drives the request a cycle later.
	detach_gate_a: assert property (
		(bus_irq_status_reg[BIT_DETACH] && enable_view[BIT_DETACH]) |=> irq)
		else $error("Enabled detach did not interrupt.");

	// With everything masked, no request appears.
	masked_quiet_a: assert property (
		(pending == '0) |=> !irq)
		else $error("Interrupt without enabled flag.");

	// An enabled frame start event, with its enable still set, gives a request two cycles later.
	sof_path_a: assert property (
		(evt_sof && enable_view[BIT_SOF]) ##1 enable_view[BIT_SOF] |=> irq)
		else $error("Frame start interrupt lost.");

	// Babble cannot be flagged before the first frame start.
	babble_hold_a: assert property (
		(host_mode && !first_sof_done && !bus_irq_status_reg[BIT_BABBLE])
		##1 host_mode |-> !bus_irq_status_reg[BIT_BABBLE])
		else $error("Babble flagged before first frame start.");

	// An event wins over a clearing read in the same cycle.
	status_set_a: assert property (
		(status_set[BIT_RESUME] && status_read) |=> bus_irq_status_reg[BIT_RESUME])
		else $error("Resume event lost on clear.");

	// A received frame number is held, upper bits zero.
	frame_capture_a: assert property (
		frame_valid |=> (frame_number_reg == {{(FREG_W-FRAME_W){1'b0}}, $past(frame_num)}))
		else $error("Frame number not captured.");

	// The upper frame bits stay zero at all times.
	frame_upper_a: assert property (
		frame_number_reg[FREG_W-1:FRAME_W] == '0)
		else $error("Frame upper bits not zero.");

	// An enabled attach flag drives the request a cycle later, in host mode.
	attach_gate_a: assert property (
		(host_mode && bus_irq_status_reg[BIT_ATTACH] && enable_view[BIT_ATTACH]) |=> irq)
		else $error("Enabled attach did not interrupt.");

	// In host mode bit 2 forwards the babble flag.
	babble_gate_a: assert property (
		(host_mode && bus_irq_status_reg[BIT_BABBLE] && enable_view[BIT_BABBLE]) |=> irq)
		else $error("Enabled babble did not interrupt.");

	// In device mode the same bit forwards the bus reset flag.
	busrst_gate_a: assert property (
		(!host_mode && bus_irq_status_reg[BIT_BUSRST] && enable_view[BIT_BUSRST]) |=> irq)
		else $error("Enabled bus reset did not interrupt.");

	// An enabled resume flag drives the request in either mode.
	resume_gate_a: assert property (
		(bus_irq_status_reg[BIT_RESUME] && enable_view[BIT_RESUME]) |=> irq)
		else $error("Enabled resume did not interrupt.");

	// An enabled suspend flag drives the request in device mode.
	suspend_gate_a: assert property (
		(!host_mode && bus_irq_status_reg[BIT_SUSPEND] && enable_view[BIT_SUSPEND]) |=> irq)
		else $error("Enabled suspend did not interrupt.");

	// The stored value is watched, since the visible one also moves with the mode.
	enable_hold_a: assert property (
		!enable_write |=> $stable(bus_irq_enable_reg))
		else $error("Enable register changed without a write.");

	// The frame number holds until the next one is received.
	frame_hold_a: assert property (
		!frame_valid |=> $stable(frame_number_reg))
		else $error("Frame number changed without a frame.");

	// A status read with no new event leaves every flag clear.
	status_clear_a: assert property (
		(status_read && (status_set == '0)) |=> (bus_irq_status_reg == '0))
		else $error("Status not cleared by read.");

endmodule // uief_top

// [inc/uief_pkg.sv]
package uief_pkg;

	// ---------------------------------------------------------------
	// Bus geometry.
	// ---------------------------------------------------------------
	localparam int unsigned AXI_ADDR_W = 8;
	localparam int unsigned AXI_DATA_W = 32;
	localparam int unsigned IDX_W      = 6;
	localparam int unsigned IDX_LSB    = 2;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_STATUS = 6'h0a;
	localparam logic [IDX_W-1:0] IDX_ENABLE = 6'h0b;
	localparam logic [IDX_W-1:0] IDX_FRAME  = 6'h0c;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Field layout and reset values.
	// ---------------------------------------------------------------
	localparam int unsigned IRQ_W   = 8;
	localparam int unsigned FRAME_W = 11;
	localparam int unsigned FREG_W  = 16;

	localparam int unsigned BIT_SUSPEND = 0;
	localparam int unsigned BIT_RESUME  = 1;
	localparam int unsigned BIT_BABBLE  = 2;
	localparam int unsigned BIT_BUSRST  = 2;
	localparam int unsigned BIT_SOF     = 3;
	localparam int unsigned BIT_ATTACH  = 4;
	localparam int unsigned BIT_DETACH  = 5;

	localparam logic [IRQ_W-1:0]  IE_RESET     = 8'h06;
	localparam logic [IRQ_W-1:0]  STATUS_RESET = 8'h00;
	localparam logic [FRAME_W-1:0] FRAME_RESET = 11'h000;
	localparam logic [IRQ_W-1:0]  MASK_HOST    = 8'h3e;
	localparam logic [IRQ_W-1:0]  MASK_DEVICE  = 8'h2f;

endpackage

// [inc/uief_reg_if.sv]
`timescale 1ns/10ps

// Strobe-level register access between the bus slave and the registers.
interface uief_reg_if;
	import uief_pkg::*;
	logic                  wr_en;
	logic [IDX_W-1:0]      wr_idx;
	logic [AXI_DATA_W-1:0] wr_data;
	logic [3:0]            wr_strb;
	logic                  wr_hit;
	logic                  rd_en;
	logic [IDX_W-1:0]      rd_idx;
	logic [AXI_DATA_W-1:0] rd_data;
	logic                  rd_hit;

	modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
		output wr_hit, rd_data, rd_hit);
endinterface

// [verilog/uief_sticky.sv]
`timescale 1ns/10ps

// Sticky flag array; a set arriving with a clear wins.
module uief_sticky
	import uief_pkg::*;
#(
	parameter int unsigned W = 8
)(
	input  wire logic         aclk,    // System clock.
	input  wire logic         aresetn, // Synchronous reset, active low.
	input  wire logic [W-1:0] set,     // Set pulses.
	input  wire logic [W-1:0] clr,     // Clear pulses.
	output logic      [W-1:0] q        // Flag state.
);

	// Flags hold until cleared.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '0;
		else
			q <= (q & ~clr) | set;
	end

endmodule // uief_sticky

// [verilog/uief_axil_slave.sv]
`timescale 1ns/10ps

// AXI4-Lite slave turning channel handshakes into register strobes.
module uief_axil_slave
	import uief_pkg::*;
(
	input  wire logic                  aclk,    // System clock.
	input  wire logic                  aresetn, // Synchronous reset, active low.
	input  wire logic [AXI_ADDR_W-1:0] awaddr,  // Write address.
	input  wire logic                  awvalid, // Write address valid.
	output logic                       awready, // Write address ready.
	input  wire logic [AXI_DATA_W-1:0] wdata,   // Write data.
	input  wire logic [3:0]            wstrb,   // Write byte enables.
	input  wire logic                  wvalid,  // Write data valid.
	output logic                       wready,  // Write data ready.
	output logic [1:0]                 bresp,   // Write response.
	output logic                       bvalid,  // Write response valid.
	input  wire logic                  bready,  // Write response ready.
	input  wire logic [AXI_ADDR_W-1:0] araddr,  // Read address.
	input  wire logic                  arvalid, // Read address valid.
	output logic                       arready, // Read address ready.
	output logic [AXI_DATA_W-1:0]      rdata,   // Read data.
	output logic [1:0]                 rresp,   // Read response.
	output logic                       rvalid,  // Read data valid.
	input  wire logic                  rready,  // Read data ready.
	uief_reg_if.slave                  bus      // Register strobes.
);

	logic                  aw_full;
	logic                  w_full;
	logic [IDX_W-1:0]      aw_idx;
	logic [AXI_DATA_W-1:0] w_data;
	logic [3:0]            w_strb;

	// Each channel is taken on its own; no new write until the response goes.
	assign awready = !aw_full && !bvalid;
	assign wready  = !w_full && !bvalid;
	assign arready = !rvalid;

	assign bus.wr_en   = aw_full && w_full && !bvalid;
	assign bus.wr_idx  = aw_idx;
	assign bus.wr_data = w_data;
	assign bus.wr_strb = w_strb;
	assign bus.rd_en   = arvalid && arready;
	assign bus.rd_idx  = araddr[AXI_ADDR_W-1:IDX_LSB];

	// Write address and data holding.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_idx  <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_full <= 1'b1;
				aw_idx  <= awaddr[AXI_ADDR_W-1:IDX_LSB];
			end
			else if (bus.wr_en)
				aw_full <= 1'b0;
			if (wvalid && wready)
			begin
				w_full <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			else if (bus.wr_en)
				w_full <= 1'b0;
		end
	end

	// Write response, raised the cycle after the strobe.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (bus.wr_en)
		begin
			bvalid <= 1'b1;
			bresp  <= bus.wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// Read data is registered so it holds while rready is low.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end
		else if (bus.rd_en)
		begin
			rvalid <= 1'b1;
			rdata  <= bus.rd_data;
			rresp  <= bus.rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

endmodule // uief_axil_slave

// [bench/uief_evt_model.sv]
`timescale 1ns/10ps

// Stand-in for the line-state logic that raises status events and frame numbers.
module uief_evt_model
	import uief_pkg::*;
(
	input  wire logic          aclk,      // System clock.
	output logic [8:0]         evt,       // One pulse line per event kind.
	output logic [FRAME_W-1:0] frame_num  // Frame number offered with a frame pulse.
);
	// Lines start quiet so nothing is sampled during reset.
	initial
	begin
		evt = 9'h000;
		frame_num = 11'h000;
	end

	// One-cycle pulse launched after an edge, so it is sampled exactly once.
	// The frame number is inverted once released, so a stale value is never mistaken for data.
	task automatic pulse(input int k, input logic [FRAME_W-1:0] fn);
		@(posedge aclk);
		evt[k] <= 1'b1;
		frame_num <= fn;
		@(posedge aclk);
		evt[k] <= 1'b0;
		frame_num <= ~fn;
	endtask
endmodule // uief_evt_model

// [bench/testbench.sv]
`timescale 1ns/10ps

module testbench;
	import uief_pkg::*;
	localparam logic [7:0] A_STAT = {IDX_STATUS, 2'b00};
	localparam logic [7:0] A_IE   = {IDX_ENABLE, 2'b00};
	localparam logic [7:0] A_FRM  = {IDX_FRAME, 2'b00};
	localparam logic [7:0] A_BAD  = 8'h3c;
	localparam int         EV_BIT [7] = '{0, 1, 2, 2, 3, 4, 5};
	localparam logic [6:0] HOST_OK = 7'b1110110;
	localparam logic [6:0] DEV_OK  = 7'b1011011;

	logic                  aclk, aresetn, host_mode, irq;
	logic [7:0]            awaddr, araddr, ie_mem;
	logic                  awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready;
	logic [31:0]           wdata, rdata, rd;
	logic [3:0]            wstrb;
	logic [1:0]            bresp, rresp, rsp;
	logic [8:0]            evt;
	logic [FRAME_W-1:0]    frame_num;
	int                    error_cnt, n_compared;

	uief_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .host_mode, .evt_suspend(evt[0]), .evt_resume(evt[1]),
		.evt_babble(evt[2]), .evt_bus_rst(evt[3]), .evt_sof(evt[4]),
		.attach_event(evt[5]), .detach_event(evt[6]), .sof_sent(evt[7]),
		.frame_valid(evt[8]), .frame_num, .irq);

	uief_evt_model evt_u (.aclk, .evt, .frame_num);

	// Free-running 25 MHz system clock.
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ---------------------------------------------------------------
	// Reporting.
	// ---------------------------------------------------------------
	task automatic results();
		$display("Compared %0d values, %0d mismatches.", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// A wait that runs out ends the run, since later steps would only cascade.
	task automatic hang();
		error_cnt++;
		$display("Error at %0t: handshake timed out", $time);
		results();
	endtask

	// ---------------------------------------------------------------
	// Bus master.
	// ---------------------------------------------------------------
	// Ready is looked at mid-cycle, where it is settled, and the transfer is the next edge.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int i;
		logic ta, tw, na, nw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		for (i = 0; i < 50 && !(ta && tw); i++)
		begin
			@(negedge aclk);
			na = awvalid && awready;
			nw = wvalid && wready;
			@(posedge aclk);
			if (na) awvalid <= 1'b0;
			if (nw) wvalid <= 1'b0;
			ta = ta | na;
			tw = tw | nw;
		end
		if (!(ta && tw)) hang();
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			if (bvalid) break;
		end
		if (i == 50) hang();
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// Ready is judged mid-cycle; at the edge itself it would race the slave.
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			if (arready) break;
		end
		if (i == 50) hang();
		@(posedge aclk);
		arvalid <= 1'b0;
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			if (rvalid) break;
		end
		if (i == 50) hang();
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi_read(a, rd, rsp);
		check(32'(rsp), 32'(RESP_OKAY));
		check(rd, e);
	endtask

	// The shadow updates only the bits of the current layout and keeps the rest, as the hardware should.
	task automatic wr_ie(input logic [7:0] v);
		logic [7:0] m;
		m = host_mode ? MASK_HOST : MASK_DEVICE;
		axi_write(A_IE, {24'h000000, v}, 4'h1, rsp);
		check(32'(rsp), 32'(RESP_OKAY));
		ie_mem = (ie_mem & ~m) | (v & m);
		rd_chk(A_IE, {24'h000000, ie_mem & m});
	endtask

	task automatic set_mode(input logic h);
		@(posedge aclk);
		host_mode <= h;
	endtask

	// One event with only its enable set, then with every enable but its own.
	task automatic gate(input int k);
		logic [7:0] b;
		logic       ok;
		b = 8'h01 << EV_BIT[k];
		ok = host_mode ? HOST_OK[k] : DEV_OK[k];
		wr_ie(b);
		evt_u.pulse(k, 11'h000);
		@(negedge aclk);
		check(32'(irq), 32'h0);
		@(negedge aclk);
		check(32'(irq), 32'(ok));
		rd_chk(A_STAT, ok ? {24'h0, b} : 32'h0);
		@(negedge aclk);
		check(32'(irq), 32'h0);
		wr_ie(~b);
		evt_u.pulse(k, 11'h000);
		repeat (2) @(negedge aclk);
		check(32'(irq), 32'h0);
		rd_chk(A_STAT, ok ? {24'h0, b} : 32'h0);
	endtask

	// ---------------------------------------------------------------
	// Main sequence.
	// ---------------------------------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		host_mode = 1'b1;
		ie_mem = IE_RESET;
		error_cnt = 0;
		n_compared = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(A_IE, 32'h06);
		rd_chk(A_FRM, 32'h0);
		rd_chk(A_STAT, 32'h0);
		axi_read(A_BAD, rd, rsp);
		check(32'(rsp), 32'(RESP_SLVERR));
		check(rd, 32'h0);
		axi_write(A_STAT, 32'hff, 4'hf, rsp);
		check(32'(rsp), 32'(RESP_OKAY));
		rd_chk(A_STAT, 32'h0);
		axi_write(A_FRM, 32'hffff, 4'hf, rsp);
		check(32'(rsp), 32'(RESP_OKAY));
		rd_chk(A_FRM, 32'h0);
		axi_write(A_BAD, 32'hff, 4'hf, rsp);
		check(32'(rsp), 32'(RESP_SLVERR));
		wr_ie(8'hff);
		axi_write(A_IE, 32'h0, 4'h0, rsp);
		rd_chk(A_IE, {24'h0, ie_mem & MASK_HOST});
		set_mode(1'b0);
		rd_chk(A_IE, {24'h0, ie_mem & MASK_DEVICE});
		wr_ie(8'hff);
		for (int k = 0; k < 7; k++)
			gate(k);
		// Babble must stay silent until a frame start has gone out.
		set_mode(1'b1);
		evt_u.pulse(2, 11'h000);
		rd_chk(A_STAT, 32'h0);
		evt_u.pulse(7, 11'h000);
		for (int k = 0; k < 7; k++)
			gate(k);
		evt_u.pulse(8, 11'h7ff);
		rd_chk(A_FRM, 32'h7ff);
		evt_u.pulse(8, 11'h123);
		rd_chk(A_FRM, 32'h123);
		// A reset in mid-run restores every register and disarms babble again.
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(A_IE, 32'h06);
		rd_chk(A_FRM, 32'h0);
		evt_u.pulse(2, 11'h000);
		evt_u.pulse(6, 11'h000);
		repeat (2) @(negedge aclk);
		check(32'(irq), 32'h0);
		rd_chk(A_STAT, 32'h20);
		results();
	end
endmodule // testbench
